/* unse_host_model.sv */
// Upstream host model: line idle, SE0, resume and end-of-packet indications
`timescale 1ns/1ps
module unse_host_model (
   input  wire logic clk,
   output logic      bus_idle,
   output logic      bus_se0,
   output logic      resume_seen,
   output logic      eop_seen
);
   // Line carries traffic at start: not idle, no SE0
   initial begin
      bus_idle    = 1'b0;
      bus_se0     = 1'b0;
      resume_seen = 1'b0;
      eop_seen    = 1'b0;
   end

   // Hold the line idle for n cycles, then traffic again
   task automatic idle_for(input int n);
      @(posedge clk);
      bus_idle <= 1'b1;
      repeat (n) @(posedge clk);
      bus_idle <= 1'b0;
   endtask : idle_for

   // Single-ended zero held for n cycles
   task automatic se0_for(input int n);
      @(posedge clk);
      bus_se0 <= 1'b1;
      repeat (n) @(posedge clk);
      bus_se0 <= 1'b0;
   endtask : se0_for

   task automatic pulse_line(input bit eop);
      @(posedge clk);
      if (eop) begin
         eop_seen <= 1'b1;
      end else begin
         resume_seen <= 1'b1;
      end
      @(posedge clk);
      eop_seen    <= 1'b0;
      resume_seen <= 1'b0;
   endtask : pulse_line
endmodule : unse_host_model

/* unse_node_event.sv */
// Node functional state, main and alternate event registers with masks and interrupt pin
`timescale 1ns/1ps
// How it works
// (R01) Node state 00 bus reset, 01 wake-up signalling, 10 active, 11 sleep.
// (R02) Bus reset state on module reset or write; then endpoint pipes disabled.
// (R03) Firmware clears/sets default address enables around the bus reset state.
// (R04) Wake-up signalling state drives resume K on the upstream port.
// (R05) Firmware holds wake-up signalling between 1 ms and 15 ms.
// (R06) Sleep puts transceivers low power, freezes endpoints; bus activity sets resume.
// (R07) Warning summary sets on unmasked warning event; clears on warning register read.
// (R08) Alternate summary sets on unmasked alternate event; clears on alternate read.
// (R09) Transmit summary is a level of unmasked transmit events.
// (R10) Frame flag sets on every frame counter load; read clears it.
// (R11) NAK summary sets on unmasked NAK event; clears on NAK register read.
// (R12) Lock-change flag sets on lock or unlock edge; main read clears it.
// (R13) Receive summary is a level of unmasked receive events.
// (R14) Main event bit 7 reads zero; main mask bit 7 is master enable.
// (R15) Interrupt only for main event bits with mask bit one.
// (R16) Short idle flag after 3 ms idle; alternate read clears it.
// (R17) Long idle flag after 5 ms idle; alternate read clears it.
// (R18) Bus reset flag after 2.5 us single-ended zero; alternate read clears it.
// (R19) Firmware writes 00 and holds reset 100 us before active.
// (R20) Resume flag on resume signalling while state is sleep; read clears.
// (R21) End-of-packet flag on valid end of packet; read clears.
// (R22) Alternate bit feeds summary only when its mask bit is one.
// (R23) Irq pin style: 00 off, 01 low open drain, 10 high, 11 low.
// (R24) Clear-on-read flags hold until read; a same-cycle event wins.
module unse_node_event (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       warn_event,
   input  wire logic       warn_reg_read,
   input  wire logic       tx_pending,
   input  wire logic       rx_pending,
   input  wire logic       nak_event,
   input  wire logic       nak_reg_read,
   input  wire logic       frame_load,
   input  wire logic       frame_unlocked_status,
   input  wire logic       bus_idle,
   input  wire logic       bus_se0,
   input  wire logic       resume_seen,
   input  wire logic       eop_seen,
   output logic            endpoints_disable,
   output logic            drive_resume_k,
   output logic            xcvr_low_power,
   output logic            freeze,
   output logic            irq_out,
   output logic            irq_oe_n
);

   // ******************************************
   // State
   // ******************************************
   typedef struct packed {
      logic [1:0]  node_state_field;
      logic [7:0]  main_event_reg;
      logic [7:0]  main_mask_reg;
      logic [7:0]  alternate_event_reg;
      logic [7:0]  alternate_mask_reg;
      logic [1:0]  irq_pin_style;
      logic        lock_prev_q;
      logic [17:0] idle_cnt_q;
      logic [6:0]  se0_cnt_q;
      logic [7:0]  rdata_q;
   } unse_state_t;

   unse_state_t s_q;
   unse_state_t s_d;

   // Counter saturating increment used by both idle and SE0 timers
   function automatic logic [17:0] unse_sat_inc(input logic [17:0] v, input logic [17:0] lim);
      unse_sat_inc = (v >= lim) ? lim : v + 18'h00001;
   endfunction : unse_sat_inc

   logic alt_read;
   logic main_read;
   logic irq_level;
   logic [7:0] alt_set;
   logic [7:0] main_view;

   assign alt_read  = rd && (addr == unse_pkg::OFF_ALT_EVENT);
   assign main_read = rd && (addr == unse_pkg::OFF_MAIN_EVENT);

   // ******************************************
   // Next state
   // ******************************************
   always_comb begin
      s_d = s_q;
      alt_set = 8'h00;
      // Idle and SE0 timers count while the condition lasts
      s_d.idle_cnt_q = bus_idle ? unse_sat_inc(s_q.idle_cnt_q, 18'(unse_pkg::LONG_IDLE_CYC)) : 18'h00000;
      s_d.se0_cnt_q  = bus_se0 ? 7'(unse_sat_inc({11'h000, s_q.se0_cnt_q}, 18'(unse_pkg::SE0_CYC)))
                               : 7'h00;
      // (R16) short idle time
      if (bus_idle && s_q.idle_cnt_q == 18'(unse_pkg::SHORT_IDLE_CYC - 1)) alt_set[unse_pkg::ALT_SHORT] = 1'b1;
      // (R17) long idle time
      if (bus_idle && s_q.idle_cnt_q == 18'(unse_pkg::LONG_IDLE_CYC - 1)) alt_set[unse_pkg::ALT_LONG] = 1'b1;
      // (R18) SE0 persisted
      if (bus_se0 && s_q.se0_cnt_q == 7'(unse_pkg::SE0_CYC - 1)) alt_set[unse_pkg::ALT_RESET] = 1'b1;
      // (R20) resume only while sleeping
      if (resume_seen && s_q.node_state_field == unse_pkg::STATE_SLEEP) alt_set[unse_pkg::ALT_RESUME] = 1'b1;
      // (R21) end of packet
      if (eop_seen) alt_set[unse_pkg::ALT_EOP] = 1'b1;
      // (R24) alternate flags: set wins over clearing read
      s_d.alternate_event_reg = (alt_read ? 8'h00 : s_q.alternate_event_reg) | alt_set;
      // (R07) warning summary
      if (warn_reg_read) s_d.main_event_reg[unse_pkg::MAIN_WARN] = 1'b0;
      if (warn_event) s_d.main_event_reg[unse_pkg::MAIN_WARN] = 1'b1;
      // (R08) alternate summary, (R22) gated by alternate mask
      if (alt_read) s_d.main_event_reg[unse_pkg::MAIN_ALT] = 1'b0;
      if (|(alt_set & s_q.alternate_mask_reg)) s_d.main_event_reg[unse_pkg::MAIN_ALT] = 1'b1;
      // (R09) transmit level
      s_d.main_event_reg[unse_pkg::MAIN_TX] = tx_pending;
      // (R13) receive level
      s_d.main_event_reg[unse_pkg::MAIN_RX] = rx_pending;
      // (R11) NAK summary
      if (nak_reg_read) s_d.main_event_reg[unse_pkg::MAIN_NAK] = 1'b0;
      if (nak_event) s_d.main_event_reg[unse_pkg::MAIN_NAK] = 1'b1;
      // (R10) frame flag, main read clears
      if (main_read) s_d.main_event_reg[unse_pkg::MAIN_FRAME] = 1'b0;
      if (frame_load) s_d.main_event_reg[unse_pkg::MAIN_FRAME] = 1'b1;
      // (R12) lock change edge
      s_d.lock_prev_q = frame_unlocked_status;
      if (main_read) s_d.main_event_reg[unse_pkg::MAIN_LOCK] = 1'b0;
      if (frame_unlocked_status != s_q.lock_prev_q) s_d.main_event_reg[unse_pkg::MAIN_LOCK] = 1'b1;
      // (R14) bit 7 always zero
      s_d.main_event_reg[unse_pkg::MAIN_MIRQ] = 1'b0;
      // Register writes
      if (wr) begin
         unique case (addr)
            // (R02) firmware may enter bus reset
            unse_pkg::OFF_NODE_STATE: s_d.node_state_field = wdata[1:0];
            unse_pkg::OFF_MAIN_MASK:  s_d.main_mask_reg = wdata;
            unse_pkg::OFF_ALT_MASK:   s_d.alternate_mask_reg = wdata & unse_pkg::ALT_MASK_BITS;
            unse_pkg::OFF_IRQ_CTRL:   s_d.irq_pin_style = wdata[1:0];
            default: ;
         endcase
      end
      // Read data, valid the cycle after the strobe
      s_d.rdata_q = 8'h00;
      if (rd) begin
         unique case (addr)
            unse_pkg::OFF_NODE_STATE: s_d.rdata_q = {6'h00, s_q.node_state_field};
            unse_pkg::OFF_MAIN_EVENT: s_d.rdata_q = s_q.main_event_reg;
            unse_pkg::OFF_MAIN_MASK:  s_d.rdata_q = s_q.main_mask_reg;
            unse_pkg::OFF_ALT_EVENT:  s_d.rdata_q = s_q.alternate_event_reg;
            unse_pkg::OFF_ALT_MASK:   s_d.rdata_q = s_q.alternate_mask_reg;
            unse_pkg::OFF_IRQ_CTRL:   s_d.rdata_q = {6'h00, s_q.irq_pin_style};
            default:                  s_d.rdata_q = 8'h00;
         endcase
      end
   end

   // Register the whole state; (R02) reset enters bus reset
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ******************************************
   // Outputs
   // ******************************************
   assign rdata = s_q.rdata_q;
   assign main_view = s_q.main_event_reg;
   // (R02) pipes disabled in bus reset
   assign endpoints_disable = (s_q.node_state_field == unse_pkg::STATE_BUS_RESET);
   // (R04) resume K while wake-up signalling
   assign drive_resume_k = (s_q.node_state_field == unse_pkg::STATE_WAKEUP_SIGNALLING);
   // (R06) low power and freeze in sleep
   assign xcvr_low_power = (s_q.node_state_field == unse_pkg::STATE_SLEEP);
   assign freeze         = xcvr_low_power;
   // (R15) masked events with master enable
   assign irq_level = s_q.main_mask_reg[unse_pkg::MAIN_MIRQ] && |(main_view[6:0] & s_q.main_mask_reg[6:0]);

   // (R23) pin style decode
   always_comb begin
      irq_out  = 1'b0;
      irq_oe_n = 1'b1;
      unique case (s_q.irq_pin_style)
         unse_pkg::IRQ_OFF:     begin irq_out = 1'b0; irq_oe_n = 1'b1; end
         unse_pkg::IRQ_LOW_OD:  begin irq_out = 1'b0; irq_oe_n = !irq_level; end
         unse_pkg::IRQ_HIGH_PP: begin irq_out = irq_level; irq_oe_n = 1'b0; end
         unse_pkg::IRQ_LOW_PP:  begin irq_out = !irq_level; irq_oe_n = 1'b0; end
      endcase
   end

   // ******************************************
   // Assertions
   // ******************************************
   // SE0 run length counted apart from the design timer, for the SE0 checks
   logic [6:0] se0_run_q;
   always_ff @(posedge clk) begin
      if (rst || !bus_se0) begin
         se0_run_q <= 7'h00;
      end else if (se0_run_q != 7'h7F) begin
         se0_run_q <= se0_run_q + 7'h01;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_bit7_zero: assert property (main_view[7] == 1'b0) else $error("main bit 7 set"); // R14
   a_irq_masked: assert property (!s_q.main_mask_reg[7] |-> !irq_level) else $error("irq without master"); // R15
   a_alt_hold: assert property (s_q.alternate_event_reg[6] && !alt_read |=> s_q.alternate_event_reg[6]) // R24
      else $error("reset flag lost");
   a_alt_clear: assert property (alt_read && !eop_seen |=> !s_q.alternate_event_reg[3]) // R21
      else $error("eop not cleared");
   a_resume_gate: assert property (resume_seen && s_q.node_state_field != 2'h3 && !alt_read // R20
      && !s_q.alternate_event_reg[7] |=> !s_q.alternate_event_reg[7]) else $error("resume out of sleep");
   a_se0_time: assert property (bus_se0 && se0_run_q == 7'(unse_pkg::SE0_CYC - 1) // R18
      |=> s_q.alternate_event_reg[6]) else $error("se0 reset flag late");
   // (R18) no flag before SE0 lasts long enough
   a_se0_early: assert property (bus_se0 && se0_run_q < 7'(unse_pkg::SE0_CYC - 1) // R18
      && !s_q.alternate_event_reg[6] |=> !s_q.alternate_event_reg[6]) else $error("se0 reset flag early");
   a_frame_set: assert property (frame_load |=> main_view[3]) else $error("frame flag missed"); // R10
   a_lock_edge: assert property ($changed(frame_unlocked_status) |=> main_view[5]) // R12
      else $error("lock change missed");
   a_tx_level: assert property (tx_pending |=> main_view[2]) else $error("tx level"); // R09
   a_wake_k: assert property (s_q.node_state_field == 2'h1 |-> drive_resume_k) else $error("no resume k"); // R04

   // (R01) state write
   a_state_write: assert property (wr && addr == unse_pkg::OFF_NODE_STATE // R01
      |=> s_q.node_state_field == $past(wdata[1:0])) else $error("state write");

   // (R02) reset entry
   a_reset_entry: assert property ($past(rst) |-> endpoints_disable) // R02
      else $error("reset entry");

   // (R02) pipes off on write
   a_pipes_off: assert property (wr && addr == unse_pkg::OFF_NODE_STATE && wdata[1:0] == 2'h0 // R02
      |=> endpoints_disable) else $error("pipes on");

   // (R06) sleep pins
   a_sleep_pins: assert property (s_q.node_state_field == 2'h3 |-> xcvr_low_power && freeze) // R06
      else $error("sleep pins");

   // (R04) no K outside wake-up
   a_no_k: assert property (s_q.node_state_field != 2'h1 |-> !drive_resume_k) // R04
      else $error("stray K");

   // (R07) warning set
   a_warn_set: assert property (warn_event |=> main_view[0]) // R07
      else $error("warn set");

   // (R07) warning clear
   a_warn_clr: assert property (warn_reg_read && !warn_event |=> !main_view[0]) // R07
      else $error("warn clear");

   // (R11) NAK set
   a_nak_set: assert property (nak_event |=> main_view[4]) // R11
      else $error("nak set");

   // (R11) NAK clear
   a_nak_clr: assert property (nak_reg_read && !nak_event |=> !main_view[4]) // R11
      else $error("nak clear");

   // (R22) unmasked alternate event
   a_alt_sum: assert property (eop_seen && s_q.alternate_mask_reg[3] |=> main_view[1]) // R22
      else $error("alt summary");

   // (R08) alternate read clears summary
   a_alt_sum_clr: assert property (alt_read && !eop_seen && !resume_seen && !bus_se0 && !bus_idle // R08
      |=> !main_view[1]) else $error("alt summary clear");

   // (R09) transmit level low
   a_tx_low: assert property (!tx_pending |=> !main_view[2]) // R09
      else $error("tx low");

   // (R13) receive level
   a_rx_level: assert property (rx_pending |=> main_view[6]) // R13
      else $error("rx level");

   // (R13) receive level low
   a_rx_low: assert property (!rx_pending |=> !main_view[6]) // R13
      else $error("rx low");

   // (R10) main read clears frame
   a_frame_clr: assert property (main_read && !frame_load |=> !main_view[3]) // R10
      else $error("frame clear");

   // (R12) main read clears lock change
   a_lock_clr: assert property (main_read && !$changed(frame_unlocked_status) |=> !main_view[5]) // R12
      else $error("lock clear");

   // (R21) end of packet sets
   a_eop_set: assert property (eop_seen |=> s_q.alternate_event_reg[3]) // R21
      else $error("eop set");

   // (R20) resume in sleep
   a_resume_set: assert property (resume_seen && s_q.node_state_field == 2'h3 // R20
      |=> s_q.alternate_event_reg[7]) else $error("resume set");

   // (R16) short idle read clear
   a_short_clr: assert property (alt_read && !bus_idle |=> !s_q.alternate_event_reg[4]) // R16
      else $error("short clear");

   // (R17) long idle read clear
   a_long_clr: assert property (alt_read && !bus_idle |=> !s_q.alternate_event_reg[5]) // R17
      else $error("long clear");

   // (R18) bus reset read clear
   a_reset_clr: assert property (alt_read && !bus_se0 |=> !s_q.alternate_event_reg[6]) // R18
      else $error("reset clear");

   // (R22) reserved mask bits
   a_alt_rsv: assert property (s_q.alternate_mask_reg[2:0] == 3'h0) // R22
      else $error("mask reserved");

   // (R23) pin off
   a_irq_off: assert property (s_q.irq_pin_style == 2'h0 |-> irq_oe_n) // R23
      else $error("pin off");

   // (R23) open drain only pulls low
   a_irq_od: assert property (s_q.irq_pin_style == 2'h1 |-> !irq_out) // R23
      else $error("open drain");

   // (R23) push-pull always drives
   a_irq_pp: assert property (s_q.irq_pin_style[1] |-> !irq_oe_n) // R23
      else $error("push-pull");

   // (R15) enabled frame event raises irq
   a_irq_fires: assert property (s_q.main_mask_reg[7] && s_q.main_mask_reg[3] // R15
      && main_view[3] |-> irq_level) else $error("irq missing");

   // (R15) mask write lands
   a_mask_write: assert property (wr && addr == unse_pkg::OFF_MAIN_MASK // R15
      |=> s_q.main_mask_reg == $past(wdata)) else $error("mask write");

   // (R14) master enable off
   a_mask_bit7: assert property (wr && addr == unse_pkg::OFF_MAIN_MASK && !wdata[7] // R14
      |=> !irq_level) else $error("master off");

   c_reset_flag: cover property (bus_se0 ##[1:100] s_q.alternate_event_reg[6]);
   c_irq: cover property (irq_level);
   c_sleep_resume: cover property (xcvr_low_power ##1 s_q.alternate_event_reg[7]);
   c_wake_idle: cover property (drive_resume_k && s_q.alternate_event_reg[4]);
endmodule : unse_node_event

/* unse_pkg.sv */
// Package: register map, field positions, reset values and timing counts for the node state and event block
package unse_pkg;
   // ******************************************
   // Register offsets
   // ******************************************
   localparam logic [3:0] OFF_NODE_STATE = 4'h0;
   localparam logic [3:0] OFF_MAIN_EVENT = 4'h1;
   localparam logic [3:0] OFF_MAIN_MASK  = 4'h2;
   localparam logic [3:0] OFF_ALT_EVENT  = 4'h3;
   localparam logic [3:0] OFF_ALT_MASK   = 4'h4;
   localparam logic [3:0] OFF_IRQ_CTRL   = 4'h5;
   localparam logic [3:0] OFF_SUB_CLEAR  = 4'h6;

   // ******************************************
   // Node states
   // ******************************************
   localparam logic [1:0] STATE_BUS_RESET         = 2'h0;
   localparam logic [1:0] STATE_WAKEUP_SIGNALLING = 2'h1;
   localparam logic [1:0] STATE_ACTIVE            = 2'h2;
   localparam logic [1:0] STATE_SLEEP             = 2'h3;

   // ******************************************
   // Main event field positions
   // ******************************************
   localparam int MAIN_WARN  = 0;
   localparam int MAIN_ALT   = 1;
   localparam int MAIN_TX    = 2;
   localparam int MAIN_FRAME = 3;
   localparam int MAIN_NAK   = 4;
   localparam int MAIN_LOCK  = 5;
   localparam int MAIN_RX    = 6;
   localparam int MAIN_MIRQ  = 7;

   // ******************************************
   // Alternate event field positions
   // ******************************************
   localparam int ALT_EOP    = 3;
   localparam int ALT_SHORT  = 4;
   localparam int ALT_LONG   = 5;
   localparam int ALT_RESET  = 6;
   localparam int ALT_RESUME = 7;

   // Writable bits of alternate mask; low three bits are reserved
   localparam logic [7:0] ALT_MASK_BITS = 8'hF8;

   // ******************************************
   // Irq pin styles
   // ******************************************
   localparam logic [1:0] IRQ_OFF       = 2'h0;
   localparam logic [1:0] IRQ_LOW_OD    = 2'h1;
   localparam logic [1:0] IRQ_HIGH_PP   = 2'h2;
   localparam logic [1:0] IRQ_LOW_PP    = 2'h3;

   // ******************************************
   // Reset values
   // ******************************************
   localparam logic [7:0] RST_BYTE = 8'h00;

   // ******************************************
   // Timing
   // ******************************************
   localparam int CLK_HZ        = 25000000;
   localparam int SHORT_IDLE_US = 3000;
   localparam int LONG_IDLE_US  = 5000;
   localparam int SE0_NS        = 2500;
   localparam int SHORT_IDLE_CYC = SHORT_IDLE_US * (CLK_HZ / 1000000);
   localparam int LONG_IDLE_CYC  = LONG_IDLE_US * (CLK_HZ / 1000000);
   localparam int SE0_CYC        = (SE0_NS * (CLK_HZ / 1000000) + 999) / 1000;
endpackage : unse_pkg

/* usb_node_state_event_logic_test.sv */
// Self-checking bench for the node state and event block
`timescale 1ns/1ps
module usb_node_state_event_logic_test;
   logic        clk, rst, wr, rd, tx_pending, rx_pending, frame_unlocked_status;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata;
   logic [4:0]  pulses;
   logic        bus_idle, bus_se0, resume_seen, eop_seen, irq_out, irq_oe_n;
   logic        endpoints_disable, drive_resume_k, xcvr_low_power, freeze;
   int          fail_count, comparisons;
   logic [31:0] seed;

   // Clock of 40 ns
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   unse_node_event u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .warn_event(pulses[0]), .nak_event(pulses[1]), .frame_load(pulses[2]), .warn_reg_read(pulses[3]),
      .nak_reg_read(pulses[4]), .tx_pending(tx_pending), .rx_pending(rx_pending),
      .frame_unlocked_status(frame_unlocked_status), .bus_idle(bus_idle), .bus_se0(bus_se0),
      .resume_seen(resume_seen), .eop_seen(eop_seen), .endpoints_disable(endpoints_disable),
      .drive_resume_k(drive_resume_k), .xcvr_low_power(xcvr_low_power), .freeze(freeze),
      .irq_out(irq_out), .irq_oe_n(irq_oe_n));

   unse_host_model u_host (.clk(clk), .bus_idle(bus_idle), .bus_se0(bus_se0), .resume_seen(resume_seen),
      .eop_seen(eop_seen));

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift

   // Expected pins {oe_n, out}; out only counts while the pin is driven
   function automatic logic [7:0] irq_exp(input int s, input bit act);
      case (s)
         0: return 8'h02;
         1: return act ? 8'h00 : 8'h02;
         2: return {7'h00, act};
         default: return {7'h00, ~act};
      endcase
   endfunction : irq_exp

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : check

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // Read strobe for one cycle, data checked in the cycle after
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(rdata, exp, "read");
   endtask : rd_chk

   task automatic pulse(input int b);
      @(posedge clk);
      pulses[b] <= 1'b1;
      @(posedge clk);
      pulses <= 5'h00;
   endtask : pulse

   task automatic test_done;
      $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done

   // Watchdog cuts a hang short
   initial begin
      repeat (99000) @(posedge clk);
      fail_count++;
      test_done();
   end

   // Main sequence
   initial begin
      int i;
      int k;
      {rst, wr, rd, addr, wdata, pulses, tx_pending, rx_pending, frame_unlocked_status} = '0;
      rst = 1'b1;
      seed = 32'h34;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 6; i++) rd_chk(4'(i), 8'h00);
      check({6'h00, endpoints_disable, irq_oe_n}, 8'h03, "reset pins");
      rd_chk(4'h9, 8'h00);
      for (i = 0; i < 4; i++) begin
         wr_reg(unse_pkg::OFF_NODE_STATE, 8'(i));
         rd_chk(unse_pkg::OFF_NODE_STATE, 8'(i));
         check({4'h0, endpoints_disable, drive_resume_k, xcvr_low_power, freeze},
            i == 0 ? 8'h08 : (i == 1 ? 8'h04 : (i == 3 ? 8'h03 : 8'h00)), "state pins");
      end
      wr_reg(unse_pkg::OFF_NODE_STATE, 8'(unse_pkg::STATE_ACTIVE));
      // Warning then NAK summaries: main read keeps them, sub read clears
      for (k = 0; k < 2; k++) begin
         pulse(k);
         rd_chk(unse_pkg::OFF_MAIN_EVENT, k ? 8'h10 : 8'h01);
         rd_chk(unse_pkg::OFF_MAIN_EVENT, k ? 8'h10 : 8'h01);
         pulse(k + 3);
         rd_chk(unse_pkg::OFF_MAIN_EVENT, 8'h00);
      end
      // Frame load and both lock edges, then same-cycle event during a read
      pulse(2);
      for (k = 0; k < 2; k++) begin
         frame_unlocked_status <= ~frame_unlocked_status;
         repeat (3) @(posedge clk);
         rd_chk(unse_pkg::OFF_MAIN_EVENT, k ? 8'h20 : 8'h28);
         rd_chk(unse_pkg::OFF_MAIN_EVENT, 8'h00);
      end
      @(posedge clk);
      pulses[2] <= 1'b1;
      addr      <= unse_pkg::OFF_MAIN_EVENT;
      rd        <= 1'b1;
      @(posedge clk);
      pulses <= 5'h00;
      rd     <= 1'b0;
      rd_chk(unse_pkg::OFF_MAIN_EVENT, 8'h08);
      // Random levels and mask values
      for (i = 0; i < 8; i++) begin
         seed = xorshift(seed);
         tx_pending <= seed[0];
         rx_pending <= seed[1];
         wr_reg(unse_pkg::OFF_MAIN_MASK, seed[15:8]);
         rd_chk(unse_pkg::OFF_MAIN_MASK, seed[15:8]);
         wr_reg(unse_pkg::OFF_ALT_MASK, seed[23:16]);
         rd_chk(unse_pkg::OFF_ALT_MASK, seed[23:16] & unse_pkg::ALT_MASK_BITS);
         rd_chk(unse_pkg::OFF_MAIN_EVENT, {1'b0, seed[1], 3'h0, seed[0], 2'h0});
      end
      tx_pending <= 1'b0;
      rx_pending <= 1'b0;
      // Pin styles against master enable and event mask; frame flag stays pending
      pulse(2);
      for (k = 0; k < 3; k++) begin
         for (i = 0; i < 4; i++) begin
            wr_reg(unse_pkg::OFF_MAIN_MASK, k == 0 ? 8'h88 : (k == 1 ? 8'h08 : 8'h80));
            wr_reg(unse_pkg::OFF_IRQ_CTRL, 8'(i));
            #1;
            check({6'h00, irq_oe_n, irq_oe_n ? 1'b0 : irq_out}, irq_exp(i, k == 0), "irq pin");
         end
      end
      rd_chk(unse_pkg::OFF_MAIN_EVENT, 8'h08);
      // Alternate events and their summary
      wr_reg(unse_pkg::OFF_ALT_MASK, 8'h40);
      u_host.se0_for(50);
      rd_chk(unse_pkg::OFF_ALT_EVENT, 8'h00);
      u_host.se0_for(70);
      rd_chk(unse_pkg::OFF_MAIN_EVENT, 8'h02);
      rd_chk(unse_pkg::OFF_ALT_EVENT, 8'h40);
      rd_chk(unse_pkg::OFF_MAIN_EVENT, 8'h00);
      // Bus reset seen: enter bus reset, hold it 100 us, then go active
      wr_reg(unse_pkg::OFF_NODE_STATE, 8'(unse_pkg::STATE_BUS_RESET));
      repeat (2500) @(posedge clk);
      check({7'h00, endpoints_disable}, 8'h01, "pipes off");
      wr_reg(unse_pkg::OFF_NODE_STATE, 8'(unse_pkg::STATE_ACTIVE));
      u_host.pulse_line(1'b0);
      rd_chk(unse_pkg::OFF_ALT_EVENT, 8'h00);
      wr_reg(unse_pkg::OFF_NODE_STATE, 8'(unse_pkg::STATE_SLEEP));
      u_host.pulse_line(1'b0);
      rd_chk(unse_pkg::OFF_MAIN_EVENT, 8'h00);
      rd_chk(unse_pkg::OFF_ALT_EVENT, 8'h80);
      u_host.pulse_line(1'b1);
      rd_chk(unse_pkg::OFF_ALT_EVENT, 8'h08);
      wr_reg(unse_pkg::OFF_ALT_MASK, 8'h10);
      // Remote wake-up held about 3 ms, inside its 1 ms to 15 ms window
      wr_reg(unse_pkg::OFF_NODE_STATE, 8'(unse_pkg::STATE_WAKEUP_SIGNALLING));
      #1;
      check({7'h00, drive_resume_k}, 8'h01, "resume k");
      u_host.idle_for(unse_pkg::SHORT_IDLE_CYC + 4);
      rd_chk(unse_pkg::OFF_MAIN_EVENT, 8'h02);
      rd_chk(unse_pkg::OFF_ALT_EVENT, 8'h10);
      wr_reg(unse_pkg::OFF_NODE_STATE, 8'(unse_pkg::STATE_ACTIVE));
      rd_chk(unse_pkg::OFF_NODE_STATE, 8'(unse_pkg::STATE_ACTIVE));
      test_done();
   end
endmodule : usb_node_state_event_logic_test
